// [verilog/pcs_pkg.sv]
/*
 pump cascade staging: shared constants, encodings and timing counts.
 assumes a 10 MHz system clock; delays, flags and run hours run on a slow control tick.
*/
//
// Behaviour
// [R01] state word holds master, on, auto, ready per motor; motor 1 lowest.
// [R02] master moves between motors only in the rotating-master mains variant.
// [R03] on flag set only when cascade automation itself connected that motor.
// [R04] auto flag mirrors an automatic operating setting, not actual running.
// [R05] ready flag comes from that motor's dedicated ready input.
// [R06] run-hour counter per motor advances only in auto under cascade control.
// [R07] pump count 1 to 4 limits which motors may be staged.
// [R08] fixed-master mains variant: master outside motor change, count is slaves.
// [R09] rotating variants pick master by least run hours; count is all pumps.
// [R10] selector use 0 ignores ready inputs, 1 evaluates them per motor.
// [R11] with selectors used, only ready motors are connected or disconnected.
// [R12] manual-off motor is not ready and never picked for connection.
// [R13] manual-on motor is not ready and excluded from automatic connection.
// [R14] manually switched-on motor never accumulates run hours.
// [R15] per-motor setting 1 auto, 2 forced on, 3 forced off, like selector.
// [R16] criterion 1 derives requests from the process controller deviation.
// [R17] criterion 2 compares output frequency with per-pump on and off levels.
// [R18] mains variants: first selection closes master output contactor, then lines.
// [R19] inverter variant: slaves get run command and frequency reference.
// [R20] requests are delayed before acting to ride out short fluctuations.
// [R21] connect delay 30 s; request dropping first restarts without connecting.
// [R22] after a connection, disconnection blocked 10 s; connections still allowed.
// [R23] flags and hours update on a control tick; reset clears all flags.

`default_nettype none

package pcs_pkg;

   // ************************************
   // encodings
   // ************************************
   localparam logic [1:0] VAR_OFF = 2'h0;
   localparam logic [1:0] VAR_MAINS_FIXED = 2'h1;
   localparam logic [1:0] VAR_MAINS_ROT = 2'h2;
   localparam logic [1:0] VAR_INVERTER = 2'h3;
   localparam logic [1:0] OP_AUTO = 2'h1;
   localparam logic [1:0] OP_ON = 2'h2;
   localparam logic [1:0] OP_OFF = 2'h3;
   localparam logic [1:0] CRIT_PID = 2'h1;
   localparam logic [1:0] CRIT_FREQ = 2'h2;
   localparam logic SEL_IGNORED = 1'b0;
   localparam logic SEL_USED = 1'b1;

   // ************************************
   // state word layout
   // ************************************
   localparam int MOTORS = 4;
   localparam int FLAGS_PER_MOTOR = 4;
   localparam int FLAG_MASTER = 0;
   localparam int FLAG_ON = 1;
   localparam int FLAG_AUTO = 2;
   localparam int FLAG_READY = 3;
   localparam logic [15:0] STATE_RESET = 16'h0000;
   localparam logic [2:0] PUMP_COUNT_MIN = 3'h1;
   localparam logic [2:0] PUMP_COUNT_MAX = 3'h4;

   // ************************************
   // timing
   // ************************************
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int TICK_PERIOD_NS = 100_000_000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
   localparam int TICKS_PER_S = 1_000_000_000 / TICK_PERIOD_NS;
   localparam int TICKS_PER_HOUR = 3600 * TICKS_PER_S;
   localparam int CONNECT_DELAY_S = 30;
   localparam int DISCONNECT_DELAY_S = 30;
   localparam int MIN_CHANGEOVER_S = 10;

   typedef enum logic [1:0] {ST_IDLE, ST_SELECT, ST_RUN} pcs_state_t;

endpackage : pcs_pkg

`default_nettype wire

// [verilog/pcs_delay_timer.sv]
/*
 request delay timer: counts control ticks while a request stands.
 assumes tick_in is a one-cycle pulse from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_delay_timer #(
   parameter int W = 16
)(
   // clock and control
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   input wire logic tick_in,
   // request
   input wire logic req_in,
   input wire logic [W-1:0] delay_in,
   output logic fire_out
);

   logic [W-1:0] cnt;
   wire [W-1:0] cnt_inc = cnt + 1'b1;

   if (W < 2)
   begin : g_bad
      $error("pcs_delay_timer: W too small");
   end

   // fires on the tick that completes the delay
   assign fire_out = req_in & tick_in & (cnt_inc >= delay_in); // [R20]

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         cnt <= '0;
      else if (clk_en_in)
      begin
         if (!req_in)
            cnt <= '0; // [R21]
         else if (tick_in)
            cnt <= fire_out ? '0 : cnt_inc;
      end
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);

   a_timer_restart: // [R21]
   assert property ((clk_en_in && !req_in) |=> cnt == '0)
      else $error("delay timer kept counting without request");

   a_timer_fire_len: // [R20]
   assert property (fire_out |-> (delay_in <= 1) || ($past(cnt) != '0) || $past(!clk_en_in))
      else $error("delay timer fired before its delay");

endmodule : pcs_delay_timer

`default_nettype wire

// [verilog/pcs_staging.sv]
/*
 pump cascade staging in the master drive: state word, run hours,
 motor selection and contactor or slave inverter commands.
 assumes all inputs synchronous to clock_in; deviation is signed percent.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_staging #(
   parameter int TICK_CYCLES = pcs_pkg::TICK_CYCLES,
   parameter int TICKS_PER_HOUR = pcs_pkg::TICKS_PER_HOUR,
   parameter int CONNECT_DELAY_S = pcs_pkg::CONNECT_DELAY_S,
   parameter int DISCONNECT_DELAY_S = pcs_pkg::DISCONNECT_DELAY_S,
   parameter int MIN_CHANGEOVER_S = pcs_pkg::MIN_CHANGEOVER_S,
   parameter int HOURS_W = 16,
   parameter int FREQ_W = 9,
   parameter int DEV_W = 8
)(
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   // configuration
   input wire logic [1:0] cascade_variant_select_in,
   input wire logic [2:0] installed_pump_count_in,
   input wire logic selector_use_in,
   input wire logic [1:0] op_setting_motor_one_in,
   input wire logic [1:0] op_setting_motor_two_in,
   input wire logic [1:0] op_setting_motor_three_in,
   input wire logic [1:0] op_setting_motor_four_in,
   input wire logic [1:0] staging_criterion_in,
   input wire logic [DEV_W-2:0] deviation_limit_in,
   input wire logic [4*FREQ_W-1:0] connect_level_in,
   input wire logic [4*FREQ_W-1:0] disconnect_level_in,
   input wire logic master_change_req_in,
   // process and selector inputs
   input wire logic signed [DEV_W-1:0] pid_deviation_in,
   input wire logic [FREQ_W-1:0] output_freq_in,
   input wire logic [3:0] motor_ready_in,
   // state and run hours
   output logic [15:0] drive_group_state_out,
   output logic [HOURS_W-1:0] run_hours_motor_one_out,
   output logic [HOURS_W-1:0] run_hours_motor_two_out,
   output logic [HOURS_W-1:0] run_hours_motor_three_out,
   output logic [HOURS_W-1:0] run_hours_motor_four_out,
   // contactor and slave commands
   output logic fixed_master_contactor_out,
   output logic [3:0] inv_contactor_out,
   output logic [3:0] line_contactor_out,
   output logic [3:0] slave_run_out,
   output logic [FREQ_W-1:0] slave_freq_ref_out
);

   // ************************************
   // sizes and checks
   // ************************************
   localparam int TCW = $clog2(TICK_CYCLES + 1) + 1;
   localparam int HSW = $clog2(TICKS_PER_HOUR + 1) + 1;
   localparam int TW = 16;

   if (TICK_CYCLES < 1 || TICKS_PER_HOUR < 1 || HOURS_W < 2 || FREQ_W < 2 || DEV_W < 2)
   begin : g_bad_size
      $error("pcs_staging: width or count parameter out of range");
   end

   if (CONNECT_DELAY_S < 0 || DISCONNECT_DELAY_S < 0 || MIN_CHANGEOVER_S < 0
       || (CONNECT_DELAY_S + DISCONNECT_DELAY_S + MIN_CHANGEOVER_S)
          * pcs_pkg::TICKS_PER_S > 65535)
   begin : g_bad_delay
      $error("pcs_staging: delay does not fit the tick counters");
   end

   // ************************************
   // helpers
   // ************************************
   function automatic logic [TW-1:0] sec_to_ticks(input int sec);
      return TW'(sec * pcs_pkg::TICKS_PER_S);
   endfunction : sec_to_ticks

   function automatic logic [2:0] clamp_count(input logic [2:0] n);
      logic [2:0] r;
      r = n;
      if (n < pcs_pkg::PUMP_COUNT_MIN)
         r = pcs_pkg::PUMP_COUNT_MIN;
      else if (n > pcs_pkg::PUMP_COUNT_MAX)
         r = pcs_pkg::PUMP_COUNT_MAX;
      return r;
   endfunction : clamp_count

   function automatic logic [1:0] first_set(input logic [3:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 3; i >= 0; i--)
         if (v[i])
            r = 2'(i);
      return r;
   endfunction : first_set

   function automatic logic [1:0] last_set(input logic [3:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 0; i < 4; i++)
         if (v[i])
            r = 2'(i);
      return r;
   endfunction : last_set

   function automatic logic [1:0] least_hours(input logic [4*HOURS_W-1:0] h,
                                              input logic [3:0] ok);
      logic [1:0] best;
      logic [HOURS_W-1:0] best_h;
      logic found;
      best = 2'h0;
      best_h = '1;
      found = 1'b0;
      for (int i = 0; i < 4; i++)
         if (ok[i] && (!found || h[i*HOURS_W +: HOURS_W] < best_h))
         begin
            best = 2'(i);
            best_h = h[i*HOURS_W +: HOURS_W];
            found = 1'b1;
         end
      return best;
   endfunction : least_hours

   localparam logic [TW-1:0] CONN_TICKS = sec_to_ticks(CONNECT_DELAY_S);
   localparam logic [TW-1:0] DROP_TICKS = sec_to_ticks(DISCONNECT_DELAY_S);
   localparam logic [TW-1:0] CHG_TICKS = sec_to_ticks(MIN_CHANGEOVER_S);

   // ************************************
   // control tick
   // ************************************
   logic [TCW-1:0] tick_cnt;
   wire tick = (tick_cnt == TCW'(TICK_CYCLES - 1));

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         tick_cnt <= '0;
      else if (clk_en_in)
         tick_cnt <= tick ? '0 : tick_cnt + 1'b1; // [R23]
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);

   // ************************************
   // per-motor decode
   // ************************************
   pcs_pkg::pcs_state_t st;
   logic [3:0] on_r;
   logic [1:0] master_idx;
   logic master_valid;
   logic [TW-1:0] block_cnt;
   logic [HOURS_W-1:0] hours [4];
   logic [HSW-1:0] sub_hours [4];
   logic [1:0] op [4];
   logic [4*HOURS_W-1:0] hours_flat;
   logic [3:0] auto_m, ready_m, forced_on, usable, in_range, is_master;
   logic [3:0] can_conn, can_drop, counting;
   logic [15:0] next_word;

   wire [1:0] variant = cascade_variant_select_in;
   wire [2:0] pump_count = clamp_count(installed_pump_count_in);
   wire mains_fixed = (variant == pcs_pkg::VAR_MAINS_FIXED);
   wire mains_rot = (variant == pcs_pkg::VAR_MAINS_ROT);
   wire inv_var = (variant == pcs_pkg::VAR_INVERTER);
   wire sel_used = (selector_use_in == pcs_pkg::SEL_USED);

   assign op[0] = op_setting_motor_one_in;
   assign op[1] = op_setting_motor_two_in;
   assign op[2] = op_setting_motor_three_in;
   assign op[3] = op_setting_motor_four_in;

   for (genvar gi = 0; gi < 4; gi++)
   begin : g_m
      assign auto_m[gi] = (op[gi] == pcs_pkg::OP_AUTO); // [R04] [R15]
      assign forced_on[gi] = (op[gi] == pcs_pkg::OP_ON); // [R15]
      assign ready_m[gi] = sel_used & motor_ready_in[gi]; // [R05] [R10]
      // with selectors used, manual positions drop the ready input, so both fall out here
      assign usable[gi] = auto_m[gi] & (!sel_used | motor_ready_in[gi]); // [R11] [R12] [R13]
      assign in_range[gi] = (3'(gi) < pump_count); // [R07]
      assign is_master[gi] = master_valid & (master_idx == 2'(gi)) & !mains_fixed; // [R08]
      assign can_conn[gi] = usable[gi] & in_range[gi] & !on_r[gi] & !is_master[gi];
      assign can_drop[gi] = usable[gi] & on_r[gi];
      assign counting[gi] = auto_m[gi] & (on_r[gi] | is_master[gi]); // [R06] [R14]
      assign hours_flat[gi*HOURS_W +: HOURS_W] = hours[gi];
      assign next_word[gi*4 + pcs_pkg::FLAG_MASTER] = is_master[gi]; // [R01]
      assign next_word[gi*4 + pcs_pkg::FLAG_ON] = on_r[gi];
      assign next_word[gi*4 + pcs_pkg::FLAG_AUTO] = auto_m[gi];
      assign next_word[gi*4 + pcs_pkg::FLAG_READY] = ready_m[gi];

      // run-hour counters, one hour per TICKS_PER_HOUR ticks
      wire hour_done = (sub_hours[gi] == HSW'(TICKS_PER_HOUR - 1));

      always_ff @(posedge clock_in or negedge rst_b_in)
      begin
         if (!rst_b_in)
         begin
            sub_hours[gi] <= '0;
            hours[gi] <= '0;
         end
         else if (clk_en_in && tick && counting[gi]) // [R06] [R14]
         begin
            sub_hours[gi] <= hour_done ? '0 : sub_hours[gi] + 1'b1;
            if (hour_done)
               hours[gi] <= hours[gi] + 1'b1;
         end
      end

      a_hours_frozen: // [R14]
      assert property ((clk_en_in && !counting[gi]) |=> $stable(hours[gi]))
         else $error("run hours advanced outside cascade auto control");

      a_forced_off: // [R15]
      assert property ((clk_en_in && op[gi] == pcs_pkg::OP_OFF)
                       |=> !line_contactor_out[gi] && !slave_run_out[gi])
         else $error("forced-off motor still commanded on");
   end

   // ************************************
   // staging requests
   // ************************************
   wire [1:0] conn_pick = first_set(can_conn);
   wire [1:0] drop_pick = last_set(can_drop);
   wire [1:0] master_pick = least_hours(hours_flat, usable & in_range); // [R09]
   wire any_conn = |can_conn;
   wire any_drop = |can_drop;
   wire any_master = |(usable & in_range);
   wire signed [DEV_W-1:0] lim_s = $signed({1'b0, deviation_limit_in});
   wire dev_hi = (pid_deviation_in >= lim_s); // [R16]
   wire dev_lo = (pid_deviation_in <= -lim_s); // [R16]
   wire [FREQ_W-1:0] on_level = connect_level_in[conn_pick*FREQ_W +: FREQ_W];
   wire [FREQ_W-1:0] off_level = disconnect_level_in[drop_pick*FREQ_W +: FREQ_W];
   wire freq_hi = (output_freq_in >= on_level); // [R17]
   wire freq_lo = (output_freq_in <= off_level); // [R17]
   wire crit_pid = (staging_criterion_in == pcs_pkg::CRIT_PID);
   wire crit_freq = (staging_criterion_in == pcs_pkg::CRIT_FREQ);
   wire running = (st == pcs_pkg::ST_RUN);
   wire conn_req = running & any_conn & ((crit_pid & dev_hi) | (crit_freq & freq_hi));
   wire drop_req = running & any_drop & ((crit_pid & dev_lo) | (crit_freq & freq_lo));
   wire conn_fire;
   wire drop_fire;
   wire drop_ok = (block_cnt == '0); // [R22]
   wire do_conn = clk_en_in & conn_fire;
   wire do_drop = clk_en_in & drop_fire & drop_ok & !do_conn;

   // both requests wait out their delay before anything switches
   pcs_delay_timer #(
      .W(TW)
   ) u_conn_timer (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .clk_en_in(clk_en_in),
      .tick_in(tick),
      .req_in(conn_req),
      .delay_in(CONN_TICKS),
      .fire_out(conn_fire)
   ); // [R20] [R21]

   pcs_delay_timer #(
      .W(TW)
   ) u_drop_timer (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .clk_en_in(clk_en_in),
      .tick_in(tick),
      .req_in(drop_req),
      .delay_in(DROP_TICKS),
      .fire_out(drop_fire)
   ); // [R20]

   // ************************************
   // staging state machine
   // ************************************
   pcs_pkg::pcs_state_t next_st;
   logic [3:0] next_on;
   logic [1:0] next_master_idx;
   logic next_master_valid;

   always_comb
   begin
      next_st = st;
      next_on = on_r;
      next_master_idx = master_idx;
      next_master_valid = master_valid;
      case (st)
         pcs_pkg::ST_IDLE:
         begin
            next_on = 4'h0;
            next_master_valid = 1'b0;
            if (variant != pcs_pkg::VAR_OFF)
               next_st = pcs_pkg::ST_SELECT;
         end
         pcs_pkg::ST_SELECT:
         begin
            next_on = 4'h0;
            if (variant == pcs_pkg::VAR_OFF)
               next_st = pcs_pkg::ST_IDLE;
            else if (mains_fixed) // [R08]
            begin
               next_master_valid = 1'b0;
               next_st = pcs_pkg::ST_RUN;
            end
            else if (tick && any_master) // [R09]
            begin
               next_master_idx = master_pick;
               next_master_valid = 1'b1;
               next_st = pcs_pkg::ST_RUN;
            end
         end
         pcs_pkg::ST_RUN:
         begin
            if (variant == pcs_pkg::VAR_OFF)
               next_st = pcs_pkg::ST_IDLE;
            // only the rotating mains variant may hand the master on
            else if (mains_rot && master_change_req_in && on_r == 4'h0) // [R02]
               next_st = pcs_pkg::ST_SELECT;
            else
            begin
               if (do_conn)
                  next_on[conn_pick] = 1'b1; // [R03]
               if (do_drop)
                  next_on[drop_pick] = 1'b0; // [R22]
               if (tick)
                  next_on = next_on & usable & in_range & ~is_master; // [R07] [R11]
            end
         end
         default:
            next_st = pcs_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         st <= pcs_pkg::ST_IDLE;
         on_r <= 4'h0;
         master_idx <= 2'h0;
         master_valid <= 1'b0;
      end
      else if (clk_en_in)
      begin
         st <= next_st;
         on_r <= next_on;
         master_idx <= next_master_idx;
         master_valid <= next_master_valid;
      end
   end

   // changeover hold: reloads on every connection
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         block_cnt <= '0;
      else if (do_conn && running)
         block_cnt <= CHG_TICKS; // [R22]
      else if (clk_en_in && tick && !drop_ok)
         block_cnt <= block_cnt - 1'b1;
   end

   // ************************************
   // outputs
   // ************************************
   wire mains = mains_fixed | mains_rot;
   wire [3:0] auto_on = on_r & usable;
   wire [3:0] next_line = mains ? ((auto_on | forced_on) & ~is_master) : 4'h0; // [R18]
   wire [3:0] next_inv = (mains_rot && running) ? is_master : 4'h0; // [R18]
   wire [3:0] next_slave = inv_var ? (auto_on | forced_on | is_master) : 4'h0; // [R19]
   wire next_fixed = mains_fixed & running; // [R18]

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         drive_group_state_out <= pcs_pkg::STATE_RESET; // [R23]
         line_contactor_out <= 4'h0;
         inv_contactor_out <= 4'h0;
         slave_run_out <= 4'h0;
         fixed_master_contactor_out <= 1'b0;
         slave_freq_ref_out <= '0;
      end
      else if (clk_en_in)
      begin
         if (tick)
            drive_group_state_out <= next_word; // [R01] [R23]
         line_contactor_out <= next_line;
         inv_contactor_out <= next_inv;
         slave_run_out <= next_slave;
         fixed_master_contactor_out <= next_fixed;
         slave_freq_ref_out <= inv_var ? output_freq_in : '0; // [R19]
      end
   end

   assign run_hours_motor_one_out = hours[0];
   assign run_hours_motor_two_out = hours[1];
   assign run_hours_motor_three_out = hours[2];
   assign run_hours_motor_four_out = hours[3];

   // ************************************
   // checks
   // ************************************
   wire [3:0] w_master = {drive_group_state_out[12], drive_group_state_out[8],
                          drive_group_state_out[4], drive_group_state_out[0]};
   wire [3:0] w_on = {drive_group_state_out[13], drive_group_state_out[9],
                      drive_group_state_out[5], drive_group_state_out[1]};
   wire [3:0] w_auto = {drive_group_state_out[14], drive_group_state_out[10],
                        drive_group_state_out[6], drive_group_state_out[2]};
   wire [3:0] w_ready = {drive_group_state_out[15], drive_group_state_out[11],
                         drive_group_state_out[7], drive_group_state_out[3]};

   a_auto_tracks_op: // [R04]
   assert property ((clk_en_in && tick) |=> w_auto == $past(auto_m))
      else $error("auto flags do not follow operating settings");

   a_ready_tracks_in: // [R05]
   assert property ((clk_en_in && tick) |=> w_ready == $past(motor_ready_in & {4{sel_used}}))
      else $error("ready flags do not follow ready inputs");

   a_on_needs_conn: // [R03]
   assert property ((on_r & ~$past(on_r)) != 4'h0 |-> $past(do_conn))
      else $error("on flag set without a cascade connection");

   a_count_limit: // [R07]
   assert property ((clk_en_in && tick && running) |=> (on_r & ~$past(in_range)) == 4'h0)
      else $error("motor beyond pump count left connected");

   a_fixed_no_master: // [R08]
   assert property ((clk_en_in && tick && mains_fixed) |=> w_master == 4'h0)
      else $error("fixed-master variant shows a cascade motor as master");

   a_master_moves: // [R02]
   assert property (($past(st) == pcs_pkg::ST_RUN && st == pcs_pkg::ST_SELECT)
                    |-> $past(cascade_variant_select_in) == pcs_pkg::VAR_MAINS_ROT)
      else $error("master reselected outside the rotating mains variant");

   a_block_loaded: // [R22]
   assert property ((do_conn && running) |=> block_cnt == CHG_TICKS)
      else $error("changeover hold not loaded after connection");

   a_drop_blocked: // [R22]
   assert property ((running && !drop_ok) |-> !do_drop ##1 $past(on_r) == (on_r | $past(on_r)))
      else $error("disconnection during changeover hold");

endmodule : pcs_staging

`default_nettype wire

// [sim/pcs_selector_model.sv]
/*
 selector switch model: two bits per motor, 0 auto, 1 manual off, 2 manual on.
 assumes the bench sets positions; only auto reports ready.
*/
`timescale 1ns/10ps
`default_nettype none
module pcs_selector_model (
   // switch positions
   input wire logic [7:0] pos_in,
   // ready inputs of the master drive
   output logic [3:0] ready_out
);
   // ************************************
   // ready decode
   // ************************************
   // manual positions never report ready
   assign ready_out = {pos_in[7:6] == 2'h0, pos_in[5:4] == 2'h0,
      pos_in[3:2] == 2'h0, pos_in[1:0] == 2'h0};
endmodule : pcs_selector_model
`default_nettype wire

// [sim/test_pcs_staging.sv]
/*
 bench for pcs_staging: integer reference model, selector model, checks.
 assumes short tick and delay parameters so a run stays brief.
*/
`timescale 1ns/10ps
`default_nettype none
module test_pcs_staging;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [1:0] var_sel = 2'h0;
   logic [1:0] op [4] = '{2'h1, 2'h1, 2'h1, 2'h1};
   logic signed [7:0] dev = 8'sh00;
   logic [6:0] lim = 7'h0a;
   logic [7:0] pos = 8'h00;
   logic sel = 1'b0;
   logic [3:0] rdy;
   logic [15:0] st;
   logic [3:0] inv;
   logic [3:0] line;
   logic en = 1'b1;
   logic mreq = 1'b0;
   logic [2:0] pumps = 3'h4;
   logic [1:0] crit = pcs_pkg::CRIT_PID;
   logic [8:0] freq = 9'h000;
   logic [35:0] lvl_on = 36'h0;
   logic [35:0] lvl_off = 36'h0;
   logic [15:0] hrs [4];
   logic [15:0] want;
   logic [3:0] srun;
   logic [8:0] fref;
   logic fixd;
   int mst = 0;
   int miscompares = 0;
   int compares = 0;
   always #50 clock_in = ~clock_in;
   pcs_selector_model sel_u (.pos_in(pos), .ready_out(rdy));
   pcs_staging #(.TICK_CYCLES(4), .TICKS_PER_HOUR(8), .CONNECT_DELAY_S(1),
      .DISCONNECT_DELAY_S(1), .MIN_CHANGEOVER_S(2)) dut_u (.clock_in(clock_in),
      .rst_b_in(rst_b_in), .clk_en_in(en), .cascade_variant_select_in(var_sel),
      .installed_pump_count_in(pumps), .selector_use_in(sel),
      .op_setting_motor_one_in(op[0]), .op_setting_motor_two_in(op[1]),
      .op_setting_motor_three_in(op[2]), .op_setting_motor_four_in(op[3]),
      .staging_criterion_in(crit), .deviation_limit_in(lim),
      .connect_level_in(lvl_on), .disconnect_level_in(lvl_off),
      .master_change_req_in(mreq), .pid_deviation_in(dev), .output_freq_in(freq),
      .motor_ready_in(rdy), .drive_group_state_out(st), .run_hours_motor_one_out(hrs[0]),
      .run_hours_motor_two_out(hrs[1]), .run_hours_motor_three_out(hrs[2]),
      .run_hours_motor_four_out(hrs[3]), .fixed_master_contactor_out(fixd),
      .inv_contactor_out(inv), .line_contactor_out(line), .slave_run_out(srun),
      .slave_freq_ref_out(fref));
   // ************************************
   // model and checks
   // ************************************
   function automatic logic [15:0] model(input int on_mask);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < 4; i++)
      begin
         s[4*i+1] = on_mask[i];
         s[4*i+2] = (op[i] == pcs_pkg::OP_AUTO);
         s[4*i+3] = sel && (pos[2*i+:2] == 2'h0);
      end
      s[4*mst] = (var_sel != pcs_pkg::VAR_MAINS_FIXED);
      return s;
   endfunction : model
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want)
      begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic ticks(input int n);
      repeat (n * 4) @(negedge clock_in);
   endtask : ticks
   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   // ************************************
   // scenarios
   // ************************************
   initial
   begin
      void'($urandom(59));
      lim = 7'h05 + 7'($urandom % 20);
      pumps = 3'h4 + 3'($urandom % 4);
      repeat (4) @(negedge clock_in);
      rst_b_in = 1'b1;
      check(st, 16'h0000);
      var_sel = pcs_pkg::VAR_MAINS_ROT;
      ticks(3);
      check(st, model(0));
      check({12'h000, inv}, 16'h0001);
      dev = 8'(lim);
      ticks(5);
      dev = 8'sh00;
      ticks(1);
      dev = 8'(lim);
      ticks(7);
      check({12'h000, line}, 16'h0000);
      ticks(5);
      check({12'h000, line}, 16'h0002);
      check(st, model(2));
      dev = -8'(lim);
      // drop delay ends inside the changeover hold, so it must wait
      ticks(12);
      check({12'h000, line}, 16'h0002);
      ticks(10);
      check({12'h000, line}, 16'h0000);
      check(st, model(0));
      check(hrs[0], 16'h0005);
      check(hrs[1], 16'h0002);
      check(hrs[2] | hrs[3], 16'h0000);
      mreq = 1'b1;
      ticks(1);
      mreq = 1'b0;
      mst = 2;
      ticks(1);
      check(st, model(0));
      check({12'h000, inv}, 16'h0004);
      crit = pcs_pkg::CRIT_FREQ;
      freq = 9'h032;
      lvl_on = {9'h064, 9'h064, 9'h064, 9'h032};
      ticks(12);
      check({12'h000, line}, 16'h0001);
      var_sel = pcs_pkg::VAR_INVERTER;
      op[3] = pcs_pkg::OP_ON;
      ticks(1);
      check({3'h0, fref, srun}, {3'h0, freq, 4'hd});
      var_sel = pcs_pkg::VAR_MAINS_FIXED;
      ticks(1);
      check({11'h000, fixd, line}, 16'h0019);
      op[2] = pcs_pkg::OP_OFF;
      pos = 8'h80;
      sel = pcs_pkg::SEL_USED;
      ticks(2);
      check(st, model(1));
      want = model(1);
      en = 1'b0;
      op[0] = pcs_pkg::OP_OFF;
      ticks(2);
      check(st, want);
      stop_test();
   end
   // a hang counts as a mismatch
   initial
   begin
      #2_000_000;
      miscompares++;
      stop_test();
   end
endmodule : test_pcs_staging
`default_nettype wire
